// ==== rtl/timer_core_pkg.sv ====
/*
  Package for the gated sixteen-bit timer core: register offsets, field
  layouts, reset values and clock source codes.
  Assumes a single 10 MHz clock domain and a byte-wide register port.
*/
package timer_core_pkg;

  // Register port widths
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [2:0] OFS_CONTROL = 3'h0;
  localparam logic [2:0] OFS_GATE = 3'h1;
  localparam logic [2:0] OFS_COUNT_LOW = 3'h2;
  localparam logic [2:0] OFS_COUNT_HIGH = 3'h3;
  localparam logic [2:0] OFS_STATUS = 3'h4;

  // Field positions in the gate and status registers
  localparam int GATE_ENABLE_POS = 0;
  localparam int IRQ_ENABLE_POS = 1;
  localparam int STAT_OVERFLOW_POS = 0;
  localparam int STAT_ARMED_POS = 1;
  localparam int STAT_RUNNING_POS = 2;

  // Clock select codes
  localparam logic [1:0] CS_INSTR = 2'h0;
  localparam logic [1:0] CS_SYSTEM = 2'h1;
  localparam logic [1:0] CS_EXTERNAL = 2'h2;
  // System clock select value that runs the secondary oscillator
  localparam logic [1:0] SCS_SEC_OSC = 2'h1;

  // Instruction clock: one tick per four system clocks
  localparam logic [1:0] INSTR_PHASE_LAST = 2'h3;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // Reset values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] PRESC_RESET = 3'h0;

  // Timer control register, bit 7 down to bit 0
  typedef struct packed {
    logic wide_access_mode_bit;
    logic sync_disable_bit;
    logic sec_osc_enable_bit;
    logic [1:0] prescale_select_field;
    logic [1:0] clock_select_field;
    logic timer_on_bit;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = '0;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage

// ==== rtl/timer_prescaler.sv ====
/*
  Prescaler: divides a stream of one-cycle ticks by 1, 2, 4 or 8.
  Assumes ticks and the clear request are on the same clock as the core.
*/
module timer_prescaler (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control
  input wire logic tick,
  input wire logic clear,
  input wire logic [1:0] sel,
  // Result
  output logic pulse,
  output logic [2:0] presc_count
);

  typedef struct packed {
    logic [2:0] cnt;
  } presc_state_s;

  presc_state_s st;
  presc_state_s next_st;
  logic [2:0] mask;

  // Mask of low bits that must all be set for the division ratio
  always_comb
  begin
    mask = 3'((4'h1 << sel) - 4'h1);
    pulse = tick && ((st.cnt & mask) == mask);
    next_st = st;
    if (clear)
    begin
      next_st.cnt = timer_core_pkg::PRESC_RESET;
    end
    else if (tick)
    begin
      next_st.cnt = pulse ? timer_core_pkg::PRESC_RESET : st.cnt + 3'h1;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '{cnt: timer_core_pkg::PRESC_RESET};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign presc_count = st.cnt;

endmodule

// ==== rtl/timer_core.sv ====
/*
  Gated sixteen-bit timer core with clock source selection, prescaler,
  optional input synchronisation and a byte-wide register port.
  Assumes gate logic outside supplies count_gate_permit on mclk, and that
  the count pin and crystal pin are asynchronous to mclk.
*/
// The strobed register port and the address map were left to the implementer.

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Sixteen-bit up-counter in two bytes; byte writes change the count, except a wide-mode high write.
// - Off when timer on is clear; gate enable defers to gate permission.
// - Clock select: 01 system, 00 instruction, 10 pin or oscillator.
// - Any timer's oscillator enable starts the shared oscillator for it.
// - System clock source advances once per system clock.
// - External source counts rising edges, synchronised or not.
// - Counter mode needs a falling edge before the first counted rise.
// - Prescaler divides the chosen clock by 1, 2, 4 or 8.
// - Prescaler hidden from software; cleared by counter byte writes, except a wide-mode high write.
// - Sync disable passes the count input without the phase stage.
// - Async external counting continues in sleep; overflow can wake.
// - Mode switches may lose or add one count; not prevented.
// - Oscillator runs on enable, go bit or system select 01.
// - Wide mode: low read latches high byte; high reads the buffer.
// - Wide mode: low write loads buffer and low byte together.
module timer_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [timer_core_pkg::ADDR_W-1:0] addr,
  input wire logic [timer_core_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [timer_core_pkg::DATA_W-1:0] rdata,
  // Pins
  input wire logic external_count_input,
  input wire logic crystal_in_pin,
  // System side
  input wire logic count_gate_permit,
  input wire logic sleep_mode,
  input wire logic sec_osc_go_bit,
  input wire logic [1:0] system_clock_select,
  input wire logic [1:0] other_osc_enable,
  // Results
  output logic [15:0] count_value,
  output logic sec_osc_run,
  output logic overflow_irq,
  output logic wake_request
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [15:0] count;
    logic [7:0] high_buf;
    timer_core_pkg::ctrl_s ctrl;
    logic gate_enable_bit;
    logic irq_enable;
    logic overflow;
    logic armed;
    logic [1:0] pin_sync;
    logic [1:0] xtal_sync;
    logic pin_phase;
    logic xtal_phase;
    logic prev_level;
    logic [1:0] instr_phase;
    logic [7:0] rdata;
  } core_state_s;

  core_state_s st;
  core_state_s next_st;
  timer_core_pkg::reg_req_s req;
  logic ext_source;
  logic async_ext;
  logic level;
  logic rise;
  logic fall;
  logic src_tick;
  logic count_enable;
  logic inc;
  logic wr_low;
  logic wr_high;
  logic presc_clear;
  logic [2:0] presc_count;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  ////////////////////////////////////////////////////////////////////////
  // Source selection and enables

  // Pin or crystal, chosen by the oscillator enable
  always_comb
  begin
    ext_source = st.ctrl.clock_select_field == timer_core_pkg::CS_EXTERNAL;
    async_ext = ext_source && st.ctrl.sync_disable_bit;
    // Async path skips the phase stage, the sync path uses it
    if (st.ctrl.sec_osc_enable_bit)
    begin
      level = st.ctrl.sync_disable_bit ? st.xtal_sync[1] : st.xtal_phase;
    end
    else
    begin
      level = st.ctrl.sync_disable_bit ? st.pin_sync[1] : st.pin_phase;
    end
    rise = level && !st.prev_level;
    fall = !level && st.prev_level;
    // Gate and sleep qualification; sleep stops all but async external
    count_enable = st.ctrl.timer_on_bit
                   && (!st.gate_enable_bit || count_gate_permit)
                   && (!sleep_mode || async_ext);
    case (st.ctrl.clock_select_field)
      timer_core_pkg::CS_SYSTEM: src_tick = 1'b1;
      timer_core_pkg::CS_INSTR:
        src_tick = st.instr_phase == timer_core_pkg::INSTR_PHASE_LAST;
      timer_core_pkg::CS_EXTERNAL: src_tick = rise && st.armed;
      default: src_tick = 1'b0;
    endcase
  end

  // Count byte write decode; in wide mode a high write fills buffer and disarms, prescaler kept
  assign wr_low = req.wr && req.addr == timer_core_pkg::OFS_COUNT_LOW;
  assign wr_high = req.wr && req.addr == timer_core_pkg::OFS_COUNT_HIGH;
  assign presc_clear = wr_low
                       || (wr_high && !st.ctrl.wide_access_mode_bit);

  // Prescaler sees only enabled ticks
  timer_prescaler u_prescaler (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(src_tick && count_enable),
    .clear(presc_clear),
    .sel(st.ctrl.prescale_select_field),
    .pulse(inc),
    .presc_count(presc_count)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_st = st;
    // Two-flop synchronisers, then the phase stage
    next_st.pin_sync = {st.pin_sync[0], external_count_input};
    next_st.xtal_sync = {st.xtal_sync[0], crystal_in_pin};
    next_st.pin_phase = st.pin_sync[1];
    next_st.xtal_phase = st.xtal_sync[1];
    next_st.prev_level = level;
    next_st.instr_phase = st.instr_phase + 2'h1;
    // Falling edge arms the counter; write or disable disarms it
    if (!st.ctrl.timer_on_bit || wr_low || wr_high)
    begin
      next_st.armed = 1'b0;
    end
    else if (fall)
    begin
      next_st.armed = 1'b1;
    end
    // Increment and rollover; a mode switch may slip one count
    if (inc)
    begin
      next_st.count = st.count + 16'h0001;
    end
    // Overflow flag; set wins over a clear in the same cycle
    if (req.wr && req.addr == timer_core_pkg::OFS_STATUS
        && req.wdata[timer_core_pkg::STAT_OVERFLOW_POS])
    begin
      next_st.overflow = 1'b0;
    end
    if (inc && st.count == timer_core_pkg::COUNT_MAX)
    begin
      next_st.overflow = 1'b1;
    end
    // Register writes; a count write beats a same-cycle increment in the bytes it writes
    if (req.wr)
    begin
      case (req.addr)
        timer_core_pkg::OFS_CONTROL:
          next_st.ctrl = timer_core_pkg::ctrl_s'(req.wdata);
        timer_core_pkg::OFS_GATE:
        begin
          next_st.gate_enable_bit =
            req.wdata[timer_core_pkg::GATE_ENABLE_POS];
          next_st.irq_enable = req.wdata[timer_core_pkg::IRQ_ENABLE_POS];
        end
        timer_core_pkg::OFS_COUNT_LOW:
          if (st.ctrl.wide_access_mode_bit)
          begin
            next_st.count = {st.high_buf, req.wdata};
          end
          else
          begin
            next_st.count[7:0] = req.wdata;
          end
        timer_core_pkg::OFS_COUNT_HIGH:
          if (st.ctrl.wide_access_mode_bit)
          begin
            next_st.high_buf = req.wdata;
          end
          else
          begin
            next_st.count[15:8] = req.wdata;
          end
        default: ;
      endcase
    end
    // Read data, one cycle after the strobe; unmapped reads zero
    next_st.rdata = timer_core_pkg::BYTE_RESET;
    if (req.rd)
    begin
      case (req.addr)
        timer_core_pkg::OFS_CONTROL: next_st.rdata = st.ctrl;
        timer_core_pkg::OFS_GATE:
          next_st.rdata = {6'h00, st.irq_enable, st.gate_enable_bit};
        timer_core_pkg::OFS_COUNT_LOW:
        begin
          next_st.rdata = st.count[7:0];
          if (st.ctrl.wide_access_mode_bit)
          begin
            next_st.high_buf = st.count[15:8];
          end
        end
        timer_core_pkg::OFS_COUNT_HIGH:
          next_st.rdata = st.ctrl.wide_access_mode_bit ? st.high_buf
                          : st.count[15:8];
        timer_core_pkg::OFS_STATUS:
          next_st.rdata = {5'h00, count_enable, st.armed, st.overflow};
        default: next_st.rdata = timer_core_pkg::BYTE_RESET;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '{count: timer_core_pkg::COUNT_RESET,
              high_buf: timer_core_pkg::BYTE_RESET,
              ctrl: timer_core_pkg::CTRL_RESET,
              rdata: timer_core_pkg::BYTE_RESET,
              default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Shared oscillator request, also kept alive through sleep
  assign sec_osc_run = st.ctrl.sec_osc_enable_bit
                       || (|other_osc_enable)
                       || sec_osc_go_bit
                       || system_clock_select == timer_core_pkg::SCS_SEC_OSC;
  assign overflow_irq = st.overflow && st.irq_enable;
  assign wake_request = overflow_irq && sleep_mode;
  assign count_value = st.count;
  assign rdata = st.rdata;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_LOW_WRITE: assert property (
    wr_low && !st.ctrl.wide_access_mode_bit
    |=> count_value[7:0] == $past(wdata))
    else $error("low byte write not taken");

  AST_OFF_HOLDS: assert property (
    !st.ctrl.timer_on_bit && !wr |=> $stable(count_value))
    else $error("count moved while timer off");

  AST_SYSTEM_RATE: assert property (
    st.ctrl.clock_select_field == timer_core_pkg::CS_SYSTEM
    && st.ctrl.prescale_select_field == 2'h0 && count_enable && !wr
    |=> count_value == $past(count_value) + 16'h0001)
    else $error("system clock source did not count each cycle");

  AST_WRITE_DISARMS: assert property (
    (wr_low || wr_high) |=> !st.armed)
    else $error("count write left input armed");

  AST_PRESC_CLEAR: assert property (
    wr_low |=> presc_count == 3'h0)
    else $error("prescaler not cleared by count write");

  AST_WIDE_READ: assert property (
    rd && addr == timer_core_pkg::OFS_COUNT_LOW
    && st.ctrl.wide_access_mode_bit
    |=> st.high_buf == $past(count_value[15:8]))
    else $error("high buffer not latched on low read");

  AST_WIDE_WRITE: assert property (
    wr_low && st.ctrl.wide_access_mode_bit
    |=> count_value == {$past(st.high_buf), $past(wdata)})
    else $error("wide write did not load both bytes");

  AST_OVERFLOW: assert property (
    inc && count_value == timer_core_pkg::COUNT_MAX
    |=> st.overflow && count_value == 16'h0000)
    else $error("rollover did not set overflow");

  AST_SLEEP_HOLD: assert property (
    sleep_mode && !async_ext && !wr |=> $stable(count_value))
    else $error("count moved in sleep outside async mode");

  AST_OSC_RUN: assert property (
    st.ctrl.sec_osc_enable_bit || sec_osc_go_bit |-> sec_osc_run)
    else $error("oscillator not requested");

  AST_INSTR_HOLD: assert property (
    st.ctrl.clock_select_field == timer_core_pkg::CS_INSTR
    && st.instr_phase != timer_core_pkg::INSTR_PHASE_LAST && !wr
    |=> $stable(count_value))
    else $error("instruction clock counted between phase ticks");

  AST_EDGE_COUNT: assert property (
    ext_source && rise && st.armed && count_enable && !wr
    && st.ctrl.prescale_select_field == 2'h0
    |=> count_value == $past(count_value) + 16'h0001)
    else $error("armed rising edge not counted");

  AST_OVF_STICKY: assert property (
    st.overflow && !(wr && addr == timer_core_pkg::OFS_STATUS
    && wdata[timer_core_pkg::STAT_OVERFLOW_POS]) |=> st.overflow)
    else $error("overflow flag dropped without a clear");

  AST_UNARMED_HOLD: assert property (
    ext_source && !st.armed && !wr |=> $stable(count_value))
    else $error("count moved before a falling edge armed it");

  COV_OVERFLOW: cover property (inc && count_value == 16'hffff);
  COV_EXT_COUNT: cover property (ext_source && inc);
  COV_WIDE_READ: cover property (
    rd && addr == timer_core_pkg::OFS_COUNT_LOW
    && st.ctrl.wide_access_mode_bit);
  COV_SLEEP_COUNT: cover property (sleep_mode && async_ext && inc);

endmodule

// ==== tb/ext_source_model.sv ====
/*
  Far-side model: the external count pin and the crystal oscillator,
  both driven as levels that stand still between bursts.
  Assumes the bench calls its tasks right after a rising mclk edge.
*/
module ext_source_model (
  // Clock
  input wire logic mclk,
  // Pins
  output logic external_count_input,
  output logic crystal_in_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle levels: pin low, crystal high
  initial
  begin
    external_count_input = 1'b0;
    crystal_in_pin = 1'b1;
  end

  // Pin burst: rising edge first, h cycles per phase, fast or slow
  task automatic pin_pulses(input int n, input int h);
    repeat (n)
    begin
      external_count_input <= 1'b1;
      repeat (h) @(posedge mclk);
      external_count_input <= 1'b0;
      repeat (h) @(posedge mclk);
    end
  endtask

  // Crystal burst: falling edge first, so every rise is countable
  task automatic xtal_pulses(input int n, input int h);
    repeat (n)
    begin
      crystal_in_pin <= 1'b0;
      repeat (h) @(posedge mclk);
      crystal_in_pin <= 1'b1;
      repeat (h) @(posedge mclk);
    end
  endtask
endmodule

// ==== tb/tb_timer_core.sv ====
/*
  Self-checking bench for the timer core: register port, clock sources,
  prescaler, gating, overflow, wide access and external counting.
  Assumes the core's register map and a 10 MHz mclk.
*/
module tb_timer_core;
  timeunit 1ns;
  timeprecision 1ns;

  // Design signals
  logic mclk, rst_n, wr, rd;
  logic [timer_core_pkg::ADDR_W-1:0] addr;
  logic [timer_core_pkg::DATA_W-1:0] wdata, rdata;
  logic external_count_input, crystal_in_pin, count_gate_permit;
  logic sleep_mode, sec_osc_go_bit, sec_osc_run, overflow_irq;
  logic wake_request;
  logic [1:0] system_clock_select, other_osc_enable;
  logic [15:0] count_value, d;
  // Bench state
  logic [7:0] exp_q[$];
  logic [7:0] lo, hi;
  logic rd_seen;
  int bad_count, samples_checked, cycles, n, h;

  timer_core DUT (
    .mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .external_count_input, .crystal_in_pin, .count_gate_permit,
    .sleep_mode, .sec_osc_go_bit, .system_clock_select,
    .other_osc_enable, .count_value, .sec_osc_run, .overflow_irq,
    .wake_request
  );

  ext_source_model src (
    .mclk, .external_count_input, .crystal_in_pin
  );

  // Clock
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  // Cycle ceiling cuts a hang short
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      bad_count++;
      final_report();
    end
  end

  // Read monitor: read data stands only in the cycle after the strobe
  always @(posedge mclk) rd_seen <= rd;
  always @(negedge mclk)
    if (rd_seen === 1'b1)
      check(16'(rdata), 16'(exp_q.pop_front()), "read");

  ////////////////////////////////////////////////////////////////////////////
  // Tasks

  // One comparison, counted
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
    input string what);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wreg(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // One-cycle read strobe; expected data goes to the monitor's queue
  task automatic rreg(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    rd <= 1'b0;
  endtask

  // Control register write
  task automatic ctl(input logic [7:0] v);
    wreg(timer_core_pkg::OFS_CONTROL, v);
  endtask

  // Counter advance over k cycles
  task automatic delta(input int k, output logic [15:0] dv);
    logic [15:0] a;
    #1 a = count_value;
    repeat (k) @(posedge mclk);
    #1 dv = count_value - a;
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  // Verdict and end of run
  task automatic final_report();
    $display("checked %0d, mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    {wr, rd, addr, wdata} = '0;
    {count_gate_permit, sleep_mode, sec_osc_go_bit} = '0;
    system_clock_select = 2'h0;
    other_osc_enable = 2'h0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    void'($urandom(32'h8266));
    // Reset values, unmapped write and reads
    wreg(3'h7, 8'hff);
    for (int a = 0; a < 8; a++) rreg(3'(a), 8'h00);
    note("reset");
    // Direct byte access
    lo = 8'($urandom);
    hi = 8'($urandom);
    wreg(timer_core_pkg::OFS_COUNT_LOW, lo);
    wreg(timer_core_pkg::OFS_COUNT_HIGH, hi);
    rreg(timer_core_pkg::OFS_COUNT_LOW, lo);
    rreg(timer_core_pkg::OFS_COUNT_HIGH, hi);
    #1 check(count_value, {hi, lo}, "bytes");
    note("bytes");
    // Every source but external, each with every prescale code
    for (int c = 0; c < 4; c++)
      for (int p = 0; p < 4; p++)
        if (c != 2)
        begin
          ctl({3'h0, 2'(p), 2'(c), 1'b1});
          repeat (4) @(posedge mclk);
          delta(64, d);
          check(d, c == 1 ? 16'(64 >> p) : c == 0 ? 16'(16 >> p) : 16'h0,
            "rate");
        end
    note("rates");
    // Prescaler left part-way, then cleared by counter writes
    ctl(8'h1b);
    repeat (3) @(posedge mclk);
    ctl(8'h1a);
    wreg(timer_core_pkg::OFS_COUNT_HIGH, 8'h00);
    wreg(timer_core_pkg::OFS_COUNT_LOW, 8'h00);
    ctl(8'h1b);
    repeat (7) @(posedge mclk);
    #1 check(count_value, 16'h0000, "prescale hold");
    @(posedge mclk);
    #1 check(count_value, 16'h0001, "prescale first");
    note("prescale clear");
    // Enable table: gate enable, timer on, gate permission
    for (int v = 0; v < 8; v++)
    begin
      wreg(timer_core_pkg::OFS_GATE, {7'h00, v[2]});
      ctl({5'h00, 2'h1, v[1]});
      count_gate_permit <= v[0];
      repeat (4) @(posedge mclk);
      delta(32, d);
      check(d, (v[1] && (!v[2] || v[0])) ? 16'h20 : 16'h0, "gate");
    end
    note("gate");
    // Rollover, sticky flag, mask and wake
    ctl(8'h00);
    wreg(timer_core_pkg::OFS_COUNT_HIGH, 8'hff);
    wreg(timer_core_pkg::OFS_COUNT_LOW, 8'hfe);
    wreg(timer_core_pkg::OFS_GATE, 8'h02);
    wreg(timer_core_pkg::OFS_STATUS, 8'h01);
    #1 check(16'(overflow_irq), 16'h0, "no overflow yet");
    ctl(8'h03);
    repeat (6) @(posedge mclk);
    ctl(8'h00);
    #1 check(16'(overflow_irq), 16'h1, "overflow");
    sleep_mode <= 1'b1;
    @(posedge mclk);
    #1 check(16'(wake_request), 16'h1, "wake");
    wreg(timer_core_pkg::OFS_GATE, 8'h00);
    @(posedge mclk);
    #1 check(16'(overflow_irq), 16'h0, "masked");
    wreg(timer_core_pkg::OFS_STATUS, 8'h01);
    wreg(timer_core_pkg::OFS_GATE, 8'h02);
    @(posedge mclk);
    #1 check(16'(overflow_irq), 16'h0, "cleared");
    sleep_mode <= 1'b0;
    note("overflow");
    // Wide access through the high buffer
    wreg(timer_core_pkg::OFS_COUNT_HIGH, 8'h56);
    ctl(8'h80);
    wreg(timer_core_pkg::OFS_COUNT_HIGH, 8'h12);
    #1 check(16'(count_value[15:8]), 16'h56, "buffer only");
    wreg(timer_core_pkg::OFS_COUNT_LOW, 8'hff);
    #1 check(count_value, 16'h12ff, "wide load");
    rreg(timer_core_pkg::OFS_COUNT_LOW, 8'hff);
    ctl(8'h83);
    repeat (300) @(posedge mclk);
    ctl(8'h80);
    rreg(timer_core_pkg::OFS_COUNT_HIGH, 8'h12);
    // 302 system ticks from 12ff: low read must latch the live high byte
    rreg(timer_core_pkg::OFS_COUNT_LOW, 8'h2d);
    rreg(timer_core_pkg::OFS_COUNT_HIGH, 8'h14);
    note("wide");
    // Pin counting: sync awake, async asleep, sync asleep
    for (int i = 0; i < 3; i++)
    begin
      ctl(8'h00);
      sleep_mode <= (i != 0);
      wreg(timer_core_pkg::OFS_COUNT_HIGH, 8'h00);
      wreg(timer_core_pkg::OFS_COUNT_LOW, 8'h00);
      ctl({1'b0, i == 1, 3'h0, 2'h2, 1'b1});
      n = 3 + $urandom % 6;
      h = 2 + $urandom % 4;
      src.pin_pulses(n + 1, h);
      repeat (6) @(posedge mclk);
      #1 check(count_value, i == 2 ? 16'h0 : 16'(n),
        "pin count");
      rreg(timer_core_pkg::OFS_STATUS, {5'h00, i != 2, 2'h2});
    end
    sleep_mode <= 1'b0;
    note("pin");
    // Crystal source, started before the timer is on
    ctl(8'h20);
    #1 check(16'(sec_osc_run), 16'h1, "osc enable");
    repeat (20) @(posedge mclk);
    wreg(timer_core_pkg::OFS_COUNT_LOW, 8'h00);
    ctl(8'h25);
    src.xtal_pulses(n, h);
    repeat (6) @(posedge mclk);
    #1 check(count_value, 16'(n), "crystal");
    // Other ways of running the oscillator
    ctl(8'h00);
    for (int j = 0; j < 4; j++)
    begin
      sec_osc_go_bit <= (j == 1);
      system_clock_select <= (j == 2) ? 2'h1 : 2'h2;
      other_osc_enable <= (j == 3) ? 2'h2 : 2'h0;
      @(posedge mclk);
      #1 check(16'(sec_osc_run), 16'(j != 0), "osc run");
    end
    note("oscillator");
    repeat (4) @(posedge mclk);
    final_report();
  end
endmodule
